// ==== include/pxir_defines.svh ====
`ifndef PXIR_DEFINES_SVH
`define PXIR_DEFINES_SVH
`define PXIR_IDX_CAP 8'h12
`define PXIR_IDX_ENT 8'h13
`define PXIR_IDX_MASK 8'h1c
`define PXIR_IDX_STAT 8'h1d
`define PXIR_IDX_RING 8'h1e
`define PXIR_STAT_BITS 11
`define PXIR_MASK_BITS 5
`define PXIR_CAP_IND_BIT 15
`define PXIR_CAP_QUAD_BIT 14
`define PXIR_CAP_SEC_BIT 12
`define PXIR_CAP_DUAL_BIT 10
`define PXIR_CAP_KEY_BIT 8
`define PXIR_RING_START_BIT 15
`define PXIR_RING_ADV_BIT 14
`define PXIR_RING_LPADV_BIT 13
`define PXIR_RING_FORCE_BIT 12
`define PXIR_RING_GO_BIT 0
`define PXIR_SWITCH_TIME_NS 1000
`define PXIR_SWITCH_CYCLES ((`PXIR_SWITCH_TIME_NS + 9) / 10)
`endif

// ==== include/pxir_pkg.sv ====
package pxir_pkg;
    typedef enum logic [1:0] {
        PXIR_ROLE_SLAVE = 2'b00,
        PXIR_ROLE_TO_SLAVE = 2'b01,
        PXIR_ROLE_TO_MASTER = 2'b10,
        PXIR_ROLE_MASTER = 2'b11
    } pxir_role_t;
    typedef enum logic [1:0] {
        PXIR_AHB_IDLE = 2'b00,
        PXIR_AHB_BUSY = 2'b01,
        PXIR_AHB_NONSEQ = 2'b10,
        PXIR_AHB_SEQ = 2'b11
    } pxir_htrans_t;
endpackage

// ==== rtl/pxir_regs.sv ====
// Operation
// RULE1: status bits pend until read, then clear
// RULE2: bits 0-3 are energy-efficient events
// RULE3: bit 4 is switchover complete
// RULE4: bits 5-9 are link-security events
// RULE5: bit 10 memory integrity; 15:11 zero
// RULE6: mask bits 0-3 sticky enables, reset zero
// RULE7: mask bit 4 enables switchover interrupt
// RULE8: capability bits 7:0 give variant BCD
// RULE9: capability bit 15 industrial temperature
// RULE10: capability bit 12 link security present
// RULE11: capability bit 8 256-bit keys
// RULE12: entropy word returns 16 random bits
// RULE13: ring bit 14 advertise; 13 partner
// RULE14: ring bit 12 forces ring resiliency
// RULE15: ring bits 5:4 encode timing role
// RULE16: stable role follows autonegotiation result
// RULE17: ring bit 0 starts switchover, self-clears
// RULE18: interrupt when pending and enabled
// RULE19: sticky bits survive soft reset
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "pxir_defines.svh"
module pxir_regs #(
    parameter logic [7:0] VARIANT_BCD = 8'h42, // arbitrary value, set per variant
    parameter logic INDUSTRIAL = 1'b0,
    parameter logic QUAD_DEVICE = 1'b0,
    parameter logic SEC_CAPABLE = 1'b1,
    parameter logic DUAL_MEDIA = 1'b0,
    parameter logic KEY256 = 1'b1,
    parameter int SWITCH_CYCLES = `PXIR_SWITCH_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic softReset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [10:0] eventIn,
    input wire logic linkPartnerAdvertises,
    input wire logic anegMaster,
    input wire logic linkUp,
    output logic ringEnable,
    output logic ringStartupEnable,
    output logic ringAdvertise,
    output logic [1:0] timingRole,
    output logic irq
);
    logic [10:0] status_reg;
    logic [4:0] mask_reg;
    logic [2:0] ringCtl_reg;
    pxir_pkg::pxir_role_t role_reg;
    logic [15:0] lfsr_reg;
    logic [31:0] swCount_reg;
    logic linkUp_reg;
    logic wrPend_reg;
    logic [7:0] wrIdx_reg;
    logic [31:0] hrdata_reg;
    logic [7:0] aIdx;
    logic take;
    logic rdStat;
    logic swDone;
    logic inSwitch;
    logic linkRise;

    function automatic logic [7:0] regIndex(input logic [31:0] a);
        regIndex = a[9:2];
    endfunction

    assign aIdx = regIndex(haddr);
    assign take = hsel && hready && htrans[1];
    assign rdStat = take && !hwrite && aIdx == `PXIR_IDX_STAT;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign inSwitch = role_reg == pxir_pkg::PXIR_ROLE_TO_MASTER || role_reg == pxir_pkg::PXIR_ROLE_TO_SLAVE;
    assign swDone = inSwitch && swCount_reg == 32'h00000001;
    assign linkRise = linkUp && !linkUp_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_reg <= 1'b0;
            wrIdx_reg <= 8'h00;
        end else begin
            wrPend_reg <= take && hwrite;
            wrIdx_reg <= aIdx;
        end
    end

    // set beats read-clear so no event is lost
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= 11'h000;
        end else begin
            status_reg <= (rdStat ? 11'h000 : status_reg) | eventIn | {6'h00, swDone, 4'h0}; // RULE1 RULE2 RULE3 RULE4 RULE5
        end
    end

    generate
        for (genvar gi = 0; gi < `PXIR_STAT_BITS; gi++) begin : g_statBit
            AST_STAT_SET: assert property ( // RULE2 RULE3 RULE4 RULE5
                @(posedge clock) disable iff (!rst_n)
                eventIn[gi]
                |=> status_reg[gi]
            ) else $error("event lost");

            AST_STAT_HOLD: assert property ( // RULE1
                @(posedge clock) disable iff (!rst_n)
                status_reg[gi] && !rdStat
                |=> status_reg[gi]
            ) else $error("pending bit dropped");
        end
    endgenerate

    AST_STAT_QUIET: assert property ( // RULE1
        @(posedge clock) disable iff (!rst_n)
        !(|eventIn) && !swDone && !rdStat
        |=> $stable(status_reg)
    ) else $error("status moved without cause");

    AST_STAT_CLEAR: assert property ( // RULE1
        @(posedge clock) disable iff (!rst_n)
        rdStat && !(|eventIn) && !swDone
        |=> status_reg == 11'h000
    ) else $error("status not cleared");

    AST_SW_DONE: assert property ( // RULE3
        @(posedge clock) disable iff (!rst_n)
        swDone
        |=> status_reg[4]
    ) else $error("switch done not flagged");

    // hardware reset only; softReset deliberately ignored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_reg <= 5'h00;
            ringCtl_reg <= 3'h0;
        end else if (wrPend_reg) begin
            if (wrIdx_reg == `PXIR_IDX_MASK) begin
                mask_reg <= hwdata[4:0]; // RULE6 RULE7 RULE19
            end
            if (wrIdx_reg == `PXIR_IDX_RING) begin
                ringCtl_reg <= {hwdata[`PXIR_RING_START_BIT], hwdata[`PXIR_RING_ADV_BIT],
                    hwdata[`PXIR_RING_FORCE_BIT]}; // RULE13 RULE14 RULE19
            end
        end
    end

    AST_MASK_WR: assert property ( // RULE6
        @(posedge clock) disable iff (!rst_n)
        wrPend_reg && wrIdx_reg == `PXIR_IDX_MASK
        |=> mask_reg == $past(hwdata[4:0])
    ) else $error("mask write");

    AST_MASK_BIT4: assert property ( // RULE7
        @(posedge clock) disable iff (!rst_n)
        wrPend_reg && wrIdx_reg == `PXIR_IDX_MASK
        |=> mask_reg[4] == $past(hwdata[4])
    ) else $error("switchover mask write");

    AST_MASK_KEEP: assert property ( // RULE19
        @(posedge clock) disable iff (!rst_n)
        !(wrPend_reg && wrIdx_reg == `PXIR_IDX_MASK)
        |=> $stable(mask_reg)
    ) else $error("mask changed without write");

    AST_SOFT: assert property ( // RULE19
        @(posedge clock) disable iff (!rst_n)
        softReset && !wrPend_reg
        |=> $stable(mask_reg)
    ) else $error("soft reset hit mask");

    AST_RING_WR: assert property ( // RULE13 RULE14
        @(posedge clock) disable iff (!rst_n)
        wrPend_reg && wrIdx_reg == `PXIR_IDX_RING
        |=> ringCtl_reg == $past({hwdata[`PXIR_RING_START_BIT], hwdata[`PXIR_RING_ADV_BIT], hwdata[`PXIR_RING_FORCE_BIT]})
    ) else $error("ring control write");

    AST_RING_KEEP: assert property ( // RULE19
        @(posedge clock) disable iff (!rst_n)
        !(wrPend_reg && wrIdx_reg == `PXIR_IDX_RING)
        |=> $stable(ringCtl_reg)
    ) else $error("ring control changed without write");

    assign ringStartupEnable = ringCtl_reg[2];
    assign ringAdvertise = ringCtl_reg[1];
    assign ringEnable = ringCtl_reg[0] || (ringCtl_reg[1] && linkPartnerAdvertises); // RULE14
    assign timingRole = role_reg;
    assign irq = |(status_reg & {6'h00, mask_reg}); // RULE18

    AST_IRQ: assert property ( // RULE18
        @(posedge clock) disable iff (!rst_n)
        1'b1
        |-> irq == |(status_reg[4:0] & mask_reg)
    ) else $error("irq mismatch");

    AST_IRQ_MASK4: assert property ( // RULE7
        @(posedge clock) disable iff (!rst_n)
        status_reg[4] && mask_reg[4]
        |-> irq
    ) else $error("switchover irq missing");

    AST_IRQ_NOMASK: assert property ( // RULE18
        @(posedge clock) disable iff (!rst_n)
        (status_reg[4:0] & mask_reg) == 5'h00
        |-> !irq
    ) else $error("irq without enabled event");

    AST_FORCE: assert property ( // RULE14
        @(posedge clock) disable iff (!rst_n)
        ringCtl_reg[0]
        |-> ringEnable
    ) else $error("force ignored");

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            linkUp_reg <= 1'b0;
        end else begin
            linkUp_reg <= linkUp;
        end
    end

    // role latches aneg result on link-up; go ignored mid-switch
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            role_reg <= pxir_pkg::PXIR_ROLE_SLAVE;
            swCount_reg <= 32'h00000000;
        end else if (linkUp && !linkUp_reg) begin
            role_reg <= anegMaster ? pxir_pkg::PXIR_ROLE_MASTER : pxir_pkg::PXIR_ROLE_SLAVE; // RULE16
            swCount_reg <= 32'h00000000;
        end else if (inSwitch) begin
            swCount_reg <= swCount_reg - 32'h00000001;
            if (swDone) begin
                role_reg <= role_reg == pxir_pkg::PXIR_ROLE_TO_MASTER ? pxir_pkg::PXIR_ROLE_MASTER
                    : pxir_pkg::PXIR_ROLE_SLAVE; // RULE15
            end
        end else if (wrPend_reg && wrIdx_reg == `PXIR_IDX_RING && hwdata[`PXIR_RING_GO_BIT] && ringEnable) begin
            role_reg <= role_reg == pxir_pkg::PXIR_ROLE_MASTER ? pxir_pkg::PXIR_ROLE_TO_SLAVE
                : pxir_pkg::PXIR_ROLE_TO_MASTER; // RULE17
            swCount_reg <= SWITCH_CYCLES;
        end
    end

    AST_ROLE_LINK: assert property ( // RULE16
        @(posedge clock) disable iff (!rst_n)
        linkRise && anegMaster
        |=> role_reg == pxir_pkg::PXIR_ROLE_MASTER
    ) else $error("role not master at link-up");

    AST_ROLE_LINK_SLAVE: assert property ( // RULE16
        @(posedge clock) disable iff (!rst_n)
        linkRise && !anegMaster
        |=> role_reg == pxir_pkg::PXIR_ROLE_SLAVE
    ) else $error("role not slave at link-up");

    AST_GO_START: assert property ( // RULE17
        @(posedge clock) disable iff (!rst_n)
        wrPend_reg && wrIdx_reg == `PXIR_IDX_RING && hwdata[0] && ringEnable && !inSwitch && !linkRise
        |=> inSwitch
    ) else $error("go did not start switchover");

    AST_GO_IGNORED: assert property ( // RULE17
        @(posedge clock) disable iff (!rst_n)
        inSwitch && !swDone && !linkRise
        |=> inSwitch
    ) else $error("switchover cut short");

    AST_NO_ENABLE_GO: assert property ( // RULE17
        @(posedge clock) disable iff (!rst_n)
        wrPend_reg && wrIdx_reg == `PXIR_IDX_RING && hwdata[0] && !ringEnable && !inSwitch && !linkRise
        |=> $stable(role_reg)
    ) else $error("go acted while ring disabled");

    AST_SW_END_M: assert property ( // RULE15
        @(posedge clock) disable iff (!rst_n)
        swDone && role_reg == pxir_pkg::PXIR_ROLE_TO_MASTER && !linkRise
        |=> role_reg == pxir_pkg::PXIR_ROLE_MASTER
    ) else $error("switch to master not settled");

    AST_SW_END_S: assert property ( // RULE15
        @(posedge clock) disable iff (!rst_n)
        swDone && role_reg == pxir_pkg::PXIR_ROLE_TO_SLAVE && !linkRise
        |=> role_reg == pxir_pkg::PXIR_ROLE_SLAVE
    ) else $error("switch to slave not settled");

    // free-running lfsr; only pseudo-random, not a true source
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_reg <= 16'hace1;
        end else begin
            lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]}; // RULE12
        end
    end

    AST_ENT: assert property ( // RULE12
        @(posedge clock) disable iff (!rst_n)
        1'b1
        |-> lfsr_reg != 16'h0000
    ) else $error("entropy stuck");

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_reg <= 32'h00000000;
        end else if (take && !hwrite) begin
            unique case (aIdx)
                `PXIR_IDX_CAP: hrdata_reg <= {16'h0000, INDUSTRIAL, QUAD_DEVICE, 1'b0, SEC_CAPABLE, 1'b0,
                    DUAL_MEDIA, 1'b0, KEY256, VARIANT_BCD}; // RULE8 RULE9 RULE10 RULE11
                `PXIR_IDX_ENT: hrdata_reg <= {16'h0000, lfsr_reg}; // RULE12
                `PXIR_IDX_MASK: hrdata_reg <= {27'h0000000, mask_reg};
                `PXIR_IDX_STAT: hrdata_reg <= {21'h000000, status_reg}; // RULE1 RULE5
                `PXIR_IDX_RING: hrdata_reg <= {16'h0000, ringCtl_reg[2:1], linkPartnerAdvertises,
                    ringCtl_reg[0], 6'h00, role_reg, 4'h0}; // RULE13 RULE15
                default: hrdata_reg <= 32'h00000000;
            endcase
        end
    end

    AST_RD_VAR: assert property ( // RULE8
        @(posedge clock) disable iff (!rst_n)
        take && !hwrite && aIdx == `PXIR_IDX_CAP
        |=> hrdata[7:0] == VARIANT_BCD
    ) else $error("variant field wrong");

    AST_RD_IND: assert property ( // RULE9
        @(posedge clock) disable iff (!rst_n)
        take && !hwrite && aIdx == `PXIR_IDX_CAP
        |=> hrdata[15] == INDUSTRIAL
    ) else $error("temperature grade wrong");

    AST_RD_SEC: assert property ( // RULE10
        @(posedge clock) disable iff (!rst_n)
        take && !hwrite && aIdx == `PXIR_IDX_CAP
        |=> hrdata[12] == SEC_CAPABLE
    ) else $error("security capability wrong");

    AST_RD_KEY: assert property ( // RULE11
        @(posedge clock) disable iff (!rst_n)
        take && !hwrite && aIdx == `PXIR_IDX_CAP
        |=> hrdata[8] == KEY256
    ) else $error("key size capability wrong");

    AST_RD_ENT: assert property ( // RULE12
        @(posedge clock) disable iff (!rst_n)
        take && !hwrite && aIdx == `PXIR_IDX_ENT
        |=> hrdata[15:0] == $past(lfsr_reg)
    ) else $error("entropy read wrong");

    AST_RD_ENT_HI: assert property ( // RULE12
        @(posedge clock) disable iff (!rst_n)
        take && !hwrite && aIdx == `PXIR_IDX_ENT
        |=> hrdata[31:16] == 16'h0000
    ) else $error("entropy upper half not zero");

    AST_RD_RING_GO: assert property ( // RULE17
        @(posedge clock) disable iff (!rst_n)
        take && !hwrite && aIdx == `PXIR_IDX_RING
        |=> hrdata[0] == 1'b0
    ) else $error("go bit reads back set");

    AST_RD_ROLE: assert property ( // RULE15
        @(posedge clock) disable iff (!rst_n)
        take && !hwrite && aIdx == `PXIR_IDX_RING
        |=> hrdata[5:4] == $past(role_reg)
    ) else $error("role field wrong");

    AST_RD_STAT: assert property ( // RULE1 RULE5
        @(posedge clock) disable iff (!rst_n)
        rdStat
        |=> hrdata[15:0] == {5'h00, $past(status_reg)}
    ) else $error("status read wrong");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pxir_defines.svh"
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic softReset = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = pxir_pkg::PXIR_AHB_IDLE;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, ringEnable, ringStartupEnable, ringAdvertise, irq;
    logic [10:0] eventIn = 11'h0;
    logic linkPartnerAdvertises = 1'b0, anegMaster = 1'b0, linkUp = 1'b0;
    logic [1:0] timingRole;
    logic [31:0] rd, rd2;
    int nMismatch = 0, testsRun = 0, cycles = 0;
    always #5 clock = ~clock;
    // short switchover so the transit states are cheap to reach
    pxir_regs #(.VARIANT_BCD(8'h37), .INDUSTRIAL(1'b1), .SWITCH_CYCLES(3)) i_dut (.clock(clock), .rst_n(rst_n),
        .softReset(softReset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .eventIn(eventIn), .linkPartnerAdvertises(linkPartnerAdvertises), .anegMaster(anegMaster),
        .linkUp(linkUp), .ringEnable(ringEnable), .ringStartupEnable(ringStartupEnable),
        .ringAdvertise(ringAdvertise), .timingRole(timingRole), .irq(irq));
    task automatic reportAndStop;
        $display("checks %0d mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            nMismatch++;
            reportAndStop();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // entered right after a rising edge; hready is sampled before moving on
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rdat);
        hsel <= 1'b1;
        htrans <= pxir_pkg::PXIR_AHB_NONSEQ;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        hsel <= 1'b0;
        htrans <= pxir_pkg::PXIR_AHB_IDLE;
        hwdata <= wd;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rdat = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        bus(1'b1, idx, wd, rd2);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0, rd);
        chk(rd, exp);
    endtask
    task automatic pulse(input logic [10:0] ev);
        eventIn <= ev;
        @(posedge clock);
        eventIn <= 11'h0;
        @(posedge clock);
    endtask
    task automatic t_ident;
        rdc(`PXIR_IDX_CAP, 32'h9137);
        wr(`PXIR_IDX_CAP, 32'h0);
        rdc(`PXIR_IDX_CAP, 32'h9137);
        bus(1'b0, `PXIR_IDX_ENT, 32'h0, rd);
        bus(1'b0, `PXIR_IDX_ENT, 32'h0, rd2);
        chk({16'h0, rd[31:16]}, 32'h0);
        chk({31'h0, rd !== rd2}, 32'h1);
        rdc(8'h05, 32'h0);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic t_irq;
        rdc(`PXIR_IDX_MASK, 32'h0);
        for (int i = 0; i < 11; i++) begin
            pulse(11'h1 << i);
            chk({31'h0, irq}, 32'h0);
            rdc(`PXIR_IDX_STAT, 32'h1 << i);
            rdc(`PXIR_IDX_STAT, 32'h0);
        end
        wr(`PXIR_IDX_MASK, 32'hffff);
        rdc(`PXIR_IDX_MASK, 32'h1f);
        pulse(11'h001);
        chk({31'h0, irq}, 32'h1);
        rdc(`PXIR_IDX_STAT, 32'h1);
        @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        wr(`PXIR_IDX_MASK, 32'h10);
        pulse(11'h020);
        chk({31'h0, irq}, 32'h0);
        rdc(`PXIR_IDX_STAT, 32'h20);
    endtask
    task automatic t_ring;
        linkPartnerAdvertises <= 1'b1;
        linkUp <= 1'b1;
        wr(`PXIR_IDX_RING, 32'h5000);
        rdc(`PXIR_IDX_RING, 32'h7000);
        chk({31'h0, ringEnable}, 32'h1);
        wr(`PXIR_IDX_RING, 32'h5001);
        // second go lands mid-switch and must be dropped
        wr(`PXIR_IDX_RING, 32'h5001);
        chk({30'h0, timingRole}, 32'h2);
        for (int n = 0; n < 20 && timingRole !== 2'b11; n++) @(posedge clock);
        repeat (6) @(posedge clock);
        rdc(`PXIR_IDX_RING, 32'h7030);
        chk({31'h0, irq}, 32'h1);
        rdc(`PXIR_IDX_STAT, 32'h10);
    endtask
    task automatic t_soft;
        softReset <= 1'b1;
        @(posedge clock);
        softReset <= 1'b0;
        @(posedge clock);
        rdc(`PXIR_IDX_MASK, 32'h10);
        rdc(`PXIR_IDX_RING, 32'h7030);
    endtask
    // hardware reset mid-run: sticky bits drop, role relatches at link-up
    task automatic t_hwreset;
        wr(`PXIR_IDX_RING, 32'hd000);
        rdc(`PXIR_IDX_RING, 32'hf030);
        chk({30'h0, ringStartupEnable, ringAdvertise}, 32'h3);
        anegMaster <= 1'b1;
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        chk({30'h0, timingRole}, 32'h3);
        rdc(`PXIR_IDX_MASK, 32'h0);
        rdc(`PXIR_IDX_RING, 32'h2030);
        chk({31'h0, ringEnable}, 32'h0);
        wr(`PXIR_IDX_RING, 32'h0001);
        @(posedge clock);
        chk({30'h0, timingRole}, 32'h3);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_ident();
        t_irq();
        t_ring();
        t_soft();
        t_hwreset();
        reportAndStop();
    end
endmodule
`default_nettype wire
